// [hw/dcsf_fifo.v]
// 4096 x 18 FIFO with sampled write/read port clocks, flags and an APB control port
//
// How it works
// [RULE1] FIFO reset returns both write and read pointers to location zero.
// [RULE2] The controller pulses the FIFO reset after power-up before writing.
// [RULE3] Reset drives half-full and almost-full high, almost-empty low.
// [RULE4] Reset raises full; empty flag low in standard, high in fall-through mode.
// [RULE5] Reset zeroes the output register and reloads both offset registers.
// [RULE6] A write edge with enable low and room stores data at the next location.
// [RULE7] A write edge with enable high stores nothing.
// [RULE8] Standard mode: full flag low when no room, high after reads, write edges only.
// [RULE9] Fall-through: input-ready high when no room, low after reads, write edges only.
// [RULE10] While full, write enable is ignored and data discarded, pointers untouched.
// [RULE11] A read edge with enable low and data loads the next word to output.
// [RULE12] A read edge with enable high holds the output register unchanged.
// [RULE13] Standard mode presents each word only on a read request.
// [RULE14] Standard: empty low after last read, reads ignored, rises after writes.
// [RULE15] Fall-through: first word reaches output on third read edge after write.
// [RULE16] Fall-through: output-ready rises only on a true read; then reads blocked.
// [RULE17] Read data drives the output bus only while output enable is low.
// [RULE18] Words are 18 bits wide on both ports.
// [RULE19] Write and read port clocks may be independent or the same clock.
// [RULE20] With no reads, full after 4096 writes standard, 4097 fall-through.
// [RULE21] Pointers advance by one per operation and wrap around.
// [RULE22] Flags use pointers passed through two port-clock stages into each side; here the flags use the one-stage copies rptr_w1 and wptr_r1.
//
// The address map and the APB slave port were decided locally.
`include "dcsf_regs.vh"

module dcsf_fifo (
    // System clock and reset
    input  wire                    pclk,
    input  wire                    presetn,
    // APB slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [11:0]             paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output reg                     pslverr,
    // Write port pins
    input  wire                    write_clock,
    input  wire                    write_enable_n,
    input  wire [`DCSF_DW-1:0]     write_data,
    input  wire                    fifo_reset_n,
    // Read port pins
    input  wire                    read_clock,
    input  wire                    read_enable_n,
    input  wire                    output_enable_n,
    output reg  [`DCSF_DW-1:0]     read_data,
    output reg                     read_data_oe,
    // Flags
    output reg                     full_n,
    output reg                     input_ready_n,
    output reg                     empty_n,
    output reg                     output_ready_n,
    output reg                     half_full_n,
    output reg                     almost_full_n,
    output reg                     almost_empty_n
);

    localparam [`DCSF_SW-1:0] SYNC_RST = `DCSF_SYNC_RST;

    // Pin sampling: three stages, value accepted when stages two and three agree
    wire [`DCSF_SW-1:0] pins;
    reg  [`DCSF_SW-1:0] s1;
    reg  [`DCSF_SW-1:0] s2;
    reg  [`DCSF_SW-1:0] s3;
    reg  [`DCSF_SW-1:0] f;
    reg  [`DCSF_SW-1:0] fp;

    assign pins = {fifo_reset_n, output_enable_n, read_enable_n, write_enable_n,
                   read_clock, write_clock, write_data};

    genvar gi;
    generate
        for (gi = 0; gi < `DCSF_SW; gi = gi + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[gi] <= SYNC_RST[gi];
                    s2[gi] <= SYNC_RST[gi];
                    s3[gi] <= SYNC_RST[gi];
                    f[gi]  <= SYNC_RST[gi];
                    fp[gi] <= SYNC_RST[gi];
                end else begin
                    s1[gi] <= pins[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi])
                        f[gi] <= s3[gi];
                    fp[gi] <= f[gi];
                end
            end
        end
    endgenerate

    // Each port clock edge is a one-cycle event; enables and data taken just before it
    wire                w_evt    = f[`DCSF_B_WCLK] & ~fp[`DCSF_B_WCLK]; // RULE19
    wire                r_evt    = f[`DCSF_B_RCLK] & ~fp[`DCSF_B_RCLK]; // RULE19
    wire                wen_n    = fp[`DCSF_B_WEN];
    wire                ren_n    = fp[`DCSF_B_REN];
    wire [`DCSF_DW-1:0] wdat     = fp[`DCSF_B_DATA_HI:0]; // RULE18
    wire                fifo_clr = ~f[`DCSF_B_FRST]; // RULE2

    // Software registers
    reg                     first_word_fallthrough;
    reg  [`DCSF_OFF_W-1:0]  empty_offset;
    reg  [`DCSF_OFF_W-1:0]  full_offset;

    // Storage and pointers
    reg  [`DCSF_DW-1:0]     mem [0:(1<<`DCSF_AW)-1];
    reg  [`DCSF_PW-1:0]     wptr;
    reg  [`DCSF_PW-1:0]     rptr;
    reg  [`DCSF_PW-1:0]     rptr_w1;
    reg  [`DCSF_PW-1:0]     rptr_w2;
    reg  [`DCSF_PW-1:0]     wptr_r1;
    reg  [`DCSF_PW-1:0]     wptr_r2;
    reg                     out_valid;

    // Write side
    reg  [`DCSF_PW-1:0] wr_level;
    reg                 mem_full;
    reg                 wr_ok;
    reg  [`DCSF_PW-1:0] next_wptr;
    reg  [`DCSF_PW-1:0] next_wr_level;
    reg                 next_full;
    reg  [`DCSF_PW-1:0] af_limit;

    // The read pointer for mem_full lags by two write edges, the one for the flags by one, so full is never too late
    always @* begin
        wr_level      = wptr - rptr_w2;
        mem_full      = (wr_level == `DCSF_DEPTH); // RULE20
        wr_ok         = w_evt & ~wen_n & ~mem_full; // RULE6 RULE7 RULE10
        next_wptr     = wptr;
        if (wr_ok)
            next_wptr = wptr + `DCSF_PTR_ONE; // RULE21
        next_wr_level = next_wptr - rptr_w1; // RULE22
        next_full     = (next_wr_level == `DCSF_DEPTH);
        af_limit      = `DCSF_DEPTH - {1'b0, full_offset};
    end

    // Write pointer and the read pointer copies taken on write edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr          <= `DCSF_PTR_ZERO;
            rptr_w1       <= `DCSF_PTR_ZERO;
            rptr_w2       <= `DCSF_PTR_ZERO;
        end else if (fifo_clr) begin
            wptr          <= `DCSF_PTR_ZERO; // RULE1
            rptr_w1       <= `DCSF_PTR_ZERO;
            rptr_w2       <= `DCSF_PTR_ZERO;
        end else if (w_evt) begin
            wptr          <= next_wptr;
            rptr_w1       <= rptr; // RULE22
            rptr_w2       <= rptr_w1;
        end
    end

    // Write-side flags move only on handled write-clock edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_n        <= 1'b1;
            input_ready_n <= 1'b0;
            half_full_n   <= 1'b1;
            almost_full_n <= 1'b1;
        end else if (fifo_clr) begin
            full_n        <= 1'b1; // RULE4
            input_ready_n <= 1'b0;
            half_full_n   <= 1'b1; // RULE3
            almost_full_n <= 1'b1; // RULE3
        end else if (w_evt) begin
            full_n        <= ~next_full; // RULE8
            input_ready_n <= next_full; // RULE9
            half_full_n   <= ~(next_wr_level > `DCSF_HALF);
            almost_full_n <= ~(next_wr_level >= af_limit);
        end
    end

    always @(posedge pclk) begin
        if (wr_ok && !fifo_clr)
            mem[wptr[`DCSF_AW-1:0]] <= wdat; // RULE6
    end

    // Read side
    reg                 mem_has;
    reg                 take_std;
    reg                 take_fw;
    reg                 drop_fw;
    reg                 take;
    reg  [`DCSF_PW-1:0] next_rptr;
    reg                 next_out_valid;
    reg  [`DCSF_PW:0]   next_rd_level;
    reg  [`DCSF_PW:0]   ae_limit;

    // A word counts only once the write pointer has passed both read-side stages
    always @* begin
        mem_has        = (wptr_r2 != rptr);
        take_std       = ~ren_n & mem_has; // RULE11 RULE13 RULE14
        take_fw        = mem_has & (~out_valid | ~ren_n); // RULE15
        drop_fw        = ~ren_n & out_valid & ~mem_has; // RULE16
        take           = r_evt & (first_word_fallthrough ? take_fw : take_std);
        next_rptr      = rptr;
        if (take)
            next_rptr  = rptr + `DCSF_PTR_ONE; // RULE21
        next_out_valid = out_valid;
        if (take)
            next_out_valid = 1'b1;
        else if (r_evt && first_word_fallthrough && drop_fw)
            next_out_valid = 1'b0; // RULE16
        // Fall-through also counts the word standing in the output register
        next_rd_level  = {1'b0, wptr_r1 - next_rptr}
                       + {{`DCSF_PW{1'b0}}, first_word_fallthrough & next_out_valid};
        ae_limit       = {2'b00, empty_offset} + {{`DCSF_PW{1'b0}}, first_word_fallthrough};
    end

    // Read pointer, output register and the write pointer copies taken on read edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr           <= `DCSF_PTR_ZERO;
            wptr_r1        <= `DCSF_PTR_ZERO;
            wptr_r2        <= `DCSF_PTR_ZERO;
            out_valid      <= 1'b0;
            read_data      <= `DCSF_DATA_ZERO;
        end else if (fifo_clr) begin
            rptr           <= `DCSF_PTR_ZERO; // RULE1
            wptr_r1        <= `DCSF_PTR_ZERO;
            wptr_r2        <= `DCSF_PTR_ZERO;
            out_valid      <= 1'b0;
            read_data      <= `DCSF_DATA_ZERO; // RULE5
        end else if (r_evt) begin
            rptr           <= next_rptr;
            wptr_r1        <= wptr; // RULE22
            wptr_r2        <= wptr_r1;
            out_valid      <= next_out_valid;
            if (take)
                read_data  <= mem[rptr[`DCSF_AW-1:0]]; // RULE11 RULE12
        end
    end

    // Read-side flags move only on handled read-clock edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_n        <= 1'b0;
            output_ready_n <= 1'b1;
            almost_empty_n <= 1'b0;
        end else if (fifo_clr) begin
            empty_n        <= 1'b0; // RULE4
            output_ready_n <= 1'b1; // RULE4
            almost_empty_n <= 1'b0; // RULE3
        end else if (r_evt) begin
            empty_n        <= (wptr_r1 != next_rptr); // RULE14
            output_ready_n <= ~next_out_valid; // RULE16
            almost_empty_n <= ~(next_rd_level <= ae_limit);
        end
    end

    // Output bus drive follows the sampled output enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            read_data_oe <= 1'b0;
        else
            read_data_oe <= ~f[`DCSF_B_OE]; // RULE17
    end

    // APB slave: zero wait states, data prepared in the setup cycle
    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire mapped = (paddr == `DCSF_ADDR_CTRL) | (paddr == `DCSF_ADDR_STATUS) |
                  (paddr == `DCSF_ADDR_LEVEL) | (paddr == `DCSF_ADDR_EOFF) |
                  (paddr == `DCSF_ADDR_FOFF);

    assign pready = access;

    reg [31:0] rd_mux;
    always @* begin
        case (paddr)
            `DCSF_ADDR_CTRL:   rd_mux = {31'h00000000, first_word_fallthrough};
            `DCSF_ADDR_STATUS: rd_mux = {24'h000000, out_valid, read_data_oe,
                                        almost_empty_n, half_full_n, almost_full_n,
                                        empty_n, input_ready_n, full_n};
            `DCSF_ADDR_LEVEL:  rd_mux = {3'h0, wr_level, 3'h0, wptr_r2 - rptr};
            `DCSF_ADDR_EOFF:   rd_mux = {20'h00000, empty_offset};
            `DCSF_ADDR_FOFF:   rd_mux = {20'h00000, full_offset};
            default:           rd_mux = `DCSF_ZERO32;
        endcase
    end

    // Read data is captured in the setup cycle and stands through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `DCSF_ZERO32;
        end else if (setup) begin
            if (pwrite)
                prdata <= `DCSF_ZERO32;
            else
                prdata <= rd_mux;
        end
    end

    // Unmapped offsets answer with an error and change nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~mapped;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_word_fallthrough         <= 1'b0;
            empty_offset <= `DCSF_EOFF_RST;
            full_offset  <= `DCSF_FOFF_RST;
        end else if (fifo_clr) begin
            // Mode may change only while the FIFO is held clear, so no word is mis-timed
            empty_offset <= `DCSF_EOFF_RST; // RULE5
            full_offset  <= `DCSF_FOFF_RST; // RULE5
            if (access && pwrite && paddr == `DCSF_ADDR_CTRL)
                first_word_fallthrough     <= pwdata[`DCSF_CTRL_FIRST_WORD_FALLTHROUGH];
        end else if (access && pwrite) begin
            // Offsets are written only outside the FIFO reset
            case (paddr)
                `DCSF_ADDR_EOFF: begin
                    empty_offset <= pwdata[`DCSF_OFF_W-1:0];
                end
                `DCSF_ADDR_FOFF: begin
                    full_offset  <= pwdata[`DCSF_OFF_W-1:0];
                end
                default: begin
                    empty_offset <= empty_offset;
                end
            endcase
        end
    end

endmodule // dcsf_fifo

// [shared/dcsf_regs.vh]
// Constants for the sampled-pin FIFO block: sizes, register map, field positions, resets
`ifndef DCSF_REGS_VH
`define DCSF_REGS_VH

// Data path and storage
`define DCSF_DW          18
`define DCSF_AW          12
`define DCSF_PW          13
`define DCSF_DEPTH       13'h1000
`define DCSF_HALF        13'h0800
`define DCSF_PTR_ZERO    13'h0000
`define DCSF_PTR_ONE     13'h0001
`define DCSF_DATA_ZERO   18'h00000

// Pin sampling vector layout
`define DCSF_SW          24
`define DCSF_B_DATA_HI   17
`define DCSF_B_WCLK      18
`define DCSF_B_RCLK      19
`define DCSF_B_WEN       20
`define DCSF_B_REN       21
`define DCSF_B_OE        22
`define DCSF_B_FRST      23
`define DCSF_SYNC_RST    24'hf00000

// Register byte offsets
`define DCSF_ADDR_CTRL   12'h000
`define DCSF_ADDR_STATUS 12'h004
`define DCSF_ADDR_LEVEL  12'h008
`define DCSF_ADDR_EOFF   12'h00c
`define DCSF_ADDR_FOFF   12'h010

// Field positions and reset values
`define DCSF_CTRL_FIRST_WORD_FALLTHROUGH   0
`define DCSF_OFF_W       12
`define DCSF_EOFF_RST    12'h07f
`define DCSF_FOFF_RST    12'h07f
`define DCSF_ZERO32      32'h00000000

`endif

// [tb/dcsf_props.sv]
// Checker for port-clock timing, flag and reset behaviour of the FIFO block
`include "dcsf_regs.vh"

module dcsf_props (
    // System
    input logic                pclk,
    input logic                presetn,
    // Port pins
    input logic                write_clock,
    input logic                read_clock,
    input logic                write_enable_n,
    input logic                read_enable_n,
    input logic                output_enable_n,
    input logic                fifo_reset_n,
    // Data and flags
    input logic [`DCSF_DW-1:0] read_data,
    input logic                read_data_oe,
    input logic                full_n,
    input logic                input_ready_n,
    input logic                empty_n,
    input logic                output_ready_n,
    input logic                half_full_n,
    input logic                almost_full_n,
    input logic                almost_empty_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wsince, rsince, stab, renhi, wenhi;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic [7:0] inc(logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // Saturating cycle counts since port events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wsince, rsince, stab, renhi, wenhi} <= 40'h0;
        end else begin
            wsince <= $rose(write_clock) ? 8'h00 : inc(wsince);
            rsince <= $rose(read_clock) ? 8'h00 : inc(rsince);
            stab   <= (!fifo_reset_n || $changed(fifo_reset_n)) ? 8'h00 : inc(stab);
            renhi  <= !read_enable_n ? 8'h00 : inc(renhi);
            wenhi  <= !write_enable_n ? 8'h00 : inc(wenhi);
        end
    end

    sequence s_rst_held;
        !fifo_reset_n [*6];
    endsequence
    sequence s_quiet;
        stab > 8'd10;
    endsequence

    property p_rst_levels;
        s_rst_held |=> half_full_n && almost_full_n && !almost_empty_n && read_data == 0;
    endproperty
    property p_rst_full;
        s_rst_held |=> full_n && !input_ready_n && !empty_n && output_ready_n;
    endproperty
    property p_ff_ir;
        full_n != input_ready_n;
    endproperty
    property p_full_edge;
        s_quiet ##0 $changed(full_n) |-> wsince <= 8'd9;
    endproperty
    property p_empty_edge;
        s_quiet ##0 $changed(empty_n) |-> rsince <= 8'd9;
    endproperty
    property p_or_edge;
        s_quiet ##0 $changed(output_ready_n) |-> rsince <= 8'd9;
    endproperty
    property p_or_true_read;
        s_quiet ##0 $rose(output_ready_n) |-> renhi <= 8'd12;
    endproperty
    property p_full_hold;
        s_quiet ##0 !full_n && renhi >= 8'd60 |=> !full_n;
    endproperty
    property p_empty_hold;
        s_quiet ##0 !empty_n && wenhi >= 8'd60 |=> !empty_n;
    endproperty
    property p_oe;
        $changed(output_enable_n) |-> ##[1:8] (read_data_oe == !output_enable_n);
    endproperty

    a_rst_levels: assert property (p_rst_levels)
        else $error("reset levels wrong");
    a_rst_full: assert property (p_rst_full)
        else $error("reset full or empty flag wrong");
    a_ff_ir: assert property (p_ff_ir)
        else $error("full and input-ready disagree");
    a_full_edge: assert property (p_full_edge)
        else $error("full flag moved off a write edge");
    a_empty_edge: assert property (p_empty_edge)
        else $error("empty flag moved off a read edge");
    a_or_edge: assert property (p_or_edge)
        else $error("output-ready moved off a read edge");
    a_or_true_read: assert property (p_or_true_read)
        else $error("output-ready rose without a read");
    a_full_hold: assert property (p_full_hold)
        else $error("full cleared without a read");
    a_empty_hold: assert property (p_empty_hold)
        else $error("empty cleared without a write");
    a_oe: assert property (p_oe)
        else $error("output enable not followed");
endmodule // dcsf_props

// [tb/dcsf_port_model.sv]
// Producer and consumer port clocks: free running, different periods
module dcsf_port_model #(
    parameter int WHALF = 5,
    parameter int RHALF = 6
) (
    // System
    input  logic pclk,
    input  logic presetn,
    // Port clocks
    output logic write_clock,
    output logic read_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    int wc, rc;

    // Each phase lasts at least four system cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc <= 0;
            rc <= 0;
            write_clock <= 1'b0;
            read_clock <= 1'b0;
        end else begin
            wc <= (wc == WHALF - 1) ? 0 : wc + 1;
            rc <= (rc == RHALF - 1) ? 0 : rc + 1;
            if (wc == WHALF - 1) write_clock <= !write_clock;
            if (rc == RHALF - 1) read_clock <= !read_clock;
        end
    end
endmodule // dcsf_port_model

// [tb/test_dcsf_fifo.sv]
// Self-checking bench for the FIFO block: traffic, flags, modes and registers
`include "dcsf_regs.vh"

module test_dcsf_fifo;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, arm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic write_clock, read_clock, write_enable_n, read_enable_n, output_enable_n;
    logic fifo_reset_n, read_data_oe, full_n, input_ready_n, empty_n, output_ready_n;
    logic half_full_n, almost_full_n, almost_empty_n;
    logic [`DCSF_DW-1:0] write_data, read_data;
    logic [`DCSF_DW-1:0] q[$];
    int n_errors, total_checks;

    dcsf_fifo dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .write_clock, .write_enable_n, .write_data, .fifo_reset_n,
        .read_clock, .read_enable_n, .output_enable_n, .read_data, .read_data_oe, .full_n,
        .input_ready_n, .empty_n, .output_ready_n, .half_full_n, .almost_full_n,
        .almost_empty_n);
    dcsf_port_model #(.WHALF(5), .RHALF(6)) model (.pclk, .presetn, .write_clock, .read_clock);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Words are noted in the queue as they are written, when note is set
    task automatic wr(int n, bit note);
        logic [`DCSF_DW-1:0] d;
        for (int i = 0; i < n; i++) begin
            @(negedge write_clock);
            @(posedge pclk);
            d = {10'($urandom), 8'(i)};
            write_enable_n <= 1'b0;
            write_data <= d;
            if (note) q.push_back(d);
        end
        @(negedge write_clock);
        @(posedge pclk);
        write_enable_n <= 1'b1;
    endtask

    task automatic rd(int n);
        repeat (n) begin
            @(negedge read_clock);
            @(posedge pclk);
            read_enable_n <= 1'b0;
        end
        @(negedge read_clock);
        @(posedge pclk);
        read_enable_n <= 1'b1;
    endtask

    task automatic frst(logic [31:0] mode);
        @(posedge pclk);
        fifo_reset_n <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, `DCSF_ADDR_CTRL, mode);
        apb(1'b0, `DCSF_ADDR_CTRL, 0);
        chk("mode", rv, mode);
        repeat (4) @(posedge pclk);
        chk("reset flags", {full_n, input_ready_n, empty_n, output_ready_n,
            half_full_n, almost_full_n, almost_empty_n, read_data}, {7'b1001110, 18'h0});
        fifo_reset_n <= 1'b1;
        repeat (10) @(posedge pclk);
        q.delete();
    endtask

    // Every change of the output register must be the oldest noted word
    always @(read_data) begin
        if (arm && q.size() == 0) chk("extra word", 32'h1, 32'h0);
        else if (arm) chk("read_data", read_data, q.pop_front());
    end

    initial begin
        #1200000;
        n_errors++;
        wrap_up;
    end

    initial begin
        {presetn, psel, penable, pwrite, arm, err} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {write_enable_n, read_enable_n, output_enable_n, fifo_reset_n} = 4'b1100;
        write_data = 18'h0;
        n_errors = 0;
        total_checks = 0;
        void'($urandom(64));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        frst(0);
        apb(1'b0, `DCSF_ADDR_EOFF, 0);
        chk("empty offset", rv, 32'h7f);
        apb(1'b0, `DCSF_ADDR_FOFF, 0);
        chk("full offset", rv, 32'h7f);
        apb(1'b0, 12'h014, 0);
        chk("unmapped", {err, rv[30:0]}, 32'h80000000);
        arm = 1'b1;
        wr(5, 1'b1);
        repeat (60) @(posedge pclk);
        chk("empty_n", empty_n, 1);
        rd(5);
        repeat (60) @(posedge pclk);
        chk("empty_n", empty_n, 0);
        rd(1);
        chk("words left", q.size(), 0);
        arm = 1'b0;
        frst(1);
        arm = 1'b1;
        wr(3, 1'b1);
        repeat (80) @(posedge pclk);
        chk("fall-through", {output_ready_n, 8'(q.size())}, 9'h002);
        rd(3);
        repeat (40) @(posedge pclk);
        chk("output_ready_n", {output_ready_n, 8'(q.size())}, 9'h100);
        rd(1);
        arm = 1'b0;
        frst(0);
        wr(4096, 1'b1);
        repeat (60) @(posedge pclk);
        chk("full flags", {full_n, half_full_n, almost_full_n}, 3'b000);
        wr(1, 1'b0);
        arm = 1'b1;
        rd(1);
        repeat (80) @(posedge pclk);
        chk("full_n", full_n, 1);
        output_enable_n <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("oe off", read_data_oe, 0);
        output_enable_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("oe on", read_data_oe, 1);
        wrap_up;
    end
endmodule // test_dcsf_fifo

bind dcsf_fifo dcsf_props u_props (.pclk, .presetn, .write_clock, .read_clock,
    .write_enable_n, .read_enable_n, .output_enable_n, .fifo_reset_n, .read_data,
    .read_data_oe, .full_n, .input_ready_n, .empty_n, .output_ready_n, .half_full_n,
    .almost_full_n, .almost_empty_n);
